// >>> pch_config_regs.sv
// PCI configuration header registers with Avalon-MM access and event interrupt
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ps
// Contract
// - EEPROM-sourced ID fields are refetched every time PCI reset deasserts.
// - Scratch byte at 40h bits 15..8 is read/write.
// - Signature word at 80h is constant; writes ignored.
// - ID word bits 31..16 return loaded device id, read-only.
// - ID word bits 15..0 return loaded vendor id, read-only.
// - Bit 31 sets on events.parity_error; an address parity error alone does not set it; resets 0.
// - Bit 30 sets when device drives system error; resets 0.
// - Bit 29 sets on master abort of own transaction; resets 0.
// - Bit 28 sets on target abort of own transaction; resets 0.
// - Bits 26..25 read fixed 01, medium select timing.
// - Bit 24 sets only on PERR seen, mastering and parity enable.
// - Bit 23 always reads 1, fast back-to-back capable.
// - Bit 20 mirrors host config register 18 bit 19, read-only.
// - Bit 8 set: address parity error asserts system error; resets 1.
// - Bit 6 zero ignores parity errors; one sets host status bit 13.
// - Bit 2 gates bus mastering; resets 1.
// - Bit 1 gates memory space response; resets 1.
// - Bit 0 is inverted I/O enable; read/write; resets 1.
module pch_config_regs #(
  parameter logic [31:0] SIGNATURE = 32'h5a5a_0001 // Arbitrary value
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Avalon-MM slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Identity from serial EEPROM loader
  input wire logic pci_reset_n,
  input wire pch_pkg::pch_ident_t eeprom_ident,
  input wire logic eeprom_valid,
  output logic eeprom_fetch,
  // Bus events from PCI core, same clock
  input wire pch_pkg::pch_events_t events,
  input wire logic device_is_master,
  input wire logic cap_list_bit,
  // Controls to the PCI core
  output pch_pkg::pch_cmd_t cmd,
  output logic serr_assert,
  output logic host_status_sys_err,
  output logic master_allowed,
  // Interrupt
  output logic irq
);
  import pch_pkg::*;

  // ------------------------------------------------------------
  // Bus handshake
  // ------------------------------------------------------------
  // One wait state per access so read data always comes from a flop.
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic req;
  logic wr_take;
  logic rd_take;

  assign req = read | write;
  assign waitrequest = req & ~ack_ff;
  assign wr_take = write & ack_ff;
  assign rd_take = read & ack_ff;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req & ~ack_ff;
    end
  end

  // Byte-lane merge for writable fields
  function automatic logic [31:0] pch_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ------------------------------------------------------------
  // Identity loader
  // ------------------------------------------------------------
  // PCI reset is a pin from outside: synchronise before use.
  logic prst_s1_ff;
  logic prst_s2_ff;
  logic prst_d_ff;
  pch_load_t ld_state_ff;
  pch_ident_t ident_ff;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prst_s1_ff <= 1'b0;
      prst_s2_ff <= 1'b0;
      prst_d_ff <= 1'b0;
    end else begin
      prst_s1_ff <= pci_reset_n;
      prst_s2_ff <= prst_s1_ff;
      prst_d_ff <= prst_s2_ff;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ld_state_ff <= PCH_LD_IDLE;
    end else begin
      case (ld_state_ff)
        PCH_LD_IDLE: begin
          if (prst_s2_ff & ~prst_d_ff) begin
            ld_state_ff <= PCH_LD_WAIT;
          end
        end
        PCH_LD_WAIT: begin
          if (!prst_s2_ff) begin
            ld_state_ff <= PCH_LD_IDLE;
          end else if (eeprom_valid) begin
            ld_state_ff <= PCH_LD_DONE;
          end
        end
        PCH_LD_DONE: begin
          if (!prst_s2_ff) begin
            ld_state_ff <= PCH_LD_IDLE;
          end
        end
        default: begin
          ld_state_ff <= PCH_LD_IDLE;
        end
      endcase
    end
  end

  assign eeprom_fetch = (ld_state_ff == PCH_LD_WAIT);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ident_ff <= '0;
    end else if (ld_state_ff == PCH_LD_WAIT && eeprom_valid) begin
      ident_ff <= eeprom_ident;
    end
  end

  // ------------------------------------------------------------
  // Command bits
  // ------------------------------------------------------------
  logic sel_cmd;
  logic [31:0] cmd_wr;

  assign sel_cmd = wr_take && address == PCH_OFF_CMDSTAT;
  assign cmd_wr = pch_merge(32'h0, writedata, byteenable);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd.system_error_response_enable <= PCH_RST_SERR_EN;
      cmd.parity_response_enable <= PCH_RST_PAR_EN;
      cmd.bus_master_enable <= PCH_RST_MST_EN;
      cmd.memory_space_enable <= PCH_RST_MEM_EN;
      cmd.io_space_disable <= PCH_RST_IO_DIS;
    end else if (sel_cmd) begin
      if (byteenable[1]) begin
        cmd.system_error_response_enable <= cmd_wr[PCH_B_SERR_EN];
      end
      if (byteenable[0]) begin
        cmd.parity_response_enable <= cmd_wr[PCH_B_PAR_EN];
        cmd.bus_master_enable <= cmd_wr[PCH_B_MST_EN];
        cmd.memory_space_enable <= cmd_wr[PCH_B_MEM_EN];
        cmd.io_space_disable <= cmd_wr[PCH_B_IO_DIS];
      end
    end
  end

  assign master_allowed = cmd.bus_master_enable;
  assign serr_assert = events.addr_parity_error & cmd.system_error_response_enable;
  assign host_status_sys_err = events.parity_error & cmd.parity_response_enable;

  // ------------------------------------------------------------
  // Status flags
  // ------------------------------------------------------------
  // Set wins over a write-one-to-clear in the same cycle.
  logic [4:0] flag_ff;
  logic [4:0] flag_set;
  logic [4:0] flag_clr;

  assign flag_set[4] = events.parity_error;
  assign flag_set[3] = serr_assert;
  assign flag_set[2] = events.master_abort & device_is_master;
  assign flag_set[1] = events.target_abort & device_is_master;
  assign flag_set[0] = events.perr_seen & device_is_master & cmd.parity_response_enable;

  assign flag_clr = (sel_cmd && byteenable[3]) ?
                    {cmd_wr[PCH_B_PERR], cmd_wr[PCH_B_SERR], cmd_wr[PCH_B_MABT],
                     cmd_wr[PCH_B_TABT], cmd_wr[PCH_B_DPR]} : 5'h00;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_ff <= 5'h00;
    end else begin
      flag_ff <= (flag_ff & ~flag_clr) | flag_set;
    end
  end

  // ------------------------------------------------------------
  // Scratch byte
  // ------------------------------------------------------------
  logic [7:0] scratch_ff;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      scratch_ff <= PCH_RST_SCRATCH;
    end else if (wr_take && address == PCH_OFF_SCRATCH && byteenable[1]) begin
      scratch_ff <= writedata[PCH_B_SCR_LO +: 8];
    end
  end

  // ------------------------------------------------------------
  // Interrupt status, clear and enable
  // ------------------------------------------------------------
  logic [PCH_NUM_EV-1:0] ev_stat_ff;
  logic [PCH_NUM_EV-1:0] ev_en_ff;
  logic [PCH_NUM_EV-1:0] ev_clr;
  logic [PCH_NUM_EV-1:0] nxt_ev_stat;
  logic [PCH_NUM_EV-1:0] nxt_ev_en;

  assign ev_clr = (wr_take && address == PCH_OFF_IRQ_CLR) ? writedata[PCH_NUM_EV-1:0] : '0;
  assign nxt_ev_stat = (ev_stat_ff & ~ev_clr) | flag_set;
  // Irq follows an enable written at the same edge, so it never lags a mask change
  assign nxt_ev_en = (wr_take && address == PCH_OFF_IRQ_EN) ? writedata[PCH_NUM_EV-1:0] :
                     ev_en_ff;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ev_stat_ff <= '0;
    end else begin
      ev_stat_ff <= nxt_ev_stat;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ev_en_ff <= '0;
    end else if (wr_take && address == PCH_OFF_IRQ_EN) begin
      ev_en_ff <= writedata[PCH_NUM_EV-1:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(nxt_ev_stat & nxt_ev_en);
    end
  end

  // ------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0;
    case (address)
      PCH_OFF_ID: rd_mux = {ident_ff.device_id, ident_ff.vendor_id};
      PCH_OFF_CMDSTAT: begin
        rd_mux[PCH_B_PERR] = flag_ff[4];
        rd_mux[PCH_B_SERR] = flag_ff[3];
        rd_mux[PCH_B_MABT] = flag_ff[2];
        rd_mux[PCH_B_TABT] = flag_ff[1];
        rd_mux[PCH_B_SEL_LO +: 2] = PCH_SEL_TIMING;
        rd_mux[PCH_B_DPR] = flag_ff[0];
        rd_mux[PCH_B_FBB] = 1'b1;
        rd_mux[PCH_B_NCAP] = cap_list_bit;
        rd_mux[PCH_B_SERR_EN] = cmd.system_error_response_enable;
        rd_mux[PCH_B_PAR_EN] = cmd.parity_response_enable;
        rd_mux[PCH_B_MST_EN] = cmd.bus_master_enable;
        rd_mux[PCH_B_MEM_EN] = cmd.memory_space_enable;
        rd_mux[PCH_B_IO_DIS] = cmd.io_space_disable;
      end
      PCH_OFF_SCRATCH: rd_mux[PCH_B_SCR_LO +: 8] = scratch_ff;
      PCH_OFF_SIGNATURE: rd_mux = SIGNATURE;
      PCH_OFF_IRQ_STAT: rd_mux[PCH_NUM_EV-1:0] = ev_stat_ff;
      PCH_OFF_IRQ_EN: rd_mux[PCH_NUM_EV-1:0] = ev_en_ff;
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_ff <= 32'h0;
    end else if (read & ~ack_ff) begin
      rdata_ff <= rd_mux;
    end
  end

  assign readdata = rdata_ff;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  sequence cmd_write_s;
    wr_take && address == PCH_OFF_CMDSTAT && byteenable[0];
  endsequence

  parity_flag_set_a: assert property (@(posedge clk) disable iff (!reset_n)
    events.parity_error |=> flag_ff[4])
    else $error("parity flag not set");
  sys_err_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
    serr_assert |-> (cmd.system_error_response_enable && events.addr_parity_error))
    else $error("system error without enable");
  serr_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
    serr_assert |=> flag_ff[3])
    else $error("system error flag missed");
  abort_flags_a: assert property (@(posedge clk) disable iff (!reset_n)
    (events.master_abort && device_is_master) |=> flag_ff[2])
    else $error("master abort flag missed");
  target_abort_a: assert property (@(posedge clk) disable iff (!reset_n)
    (events.target_abort && device_is_master) |=> flag_ff[1])
    else $error("target abort flag missed");
  dpr_cause_a: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(flag_ff[0]) |-> $past(events.perr_seen && device_is_master
                                && cmd.parity_response_enable))
    else $error("data parity flag without cause");
  master_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
    cmd_write_s |=> (master_allowed == $past(writedata[PCH_B_MST_EN])))
    else $error("master enable not written");
  host_perr_a: assert property (@(posedge clk) disable iff (!reset_n)
    (events.parity_error && !cmd.parity_response_enable) |-> !host_status_sys_err)
    else $error("parity reported while disabled");
  signature_read_a: assert property (@(posedge clk) disable iff (!reset_n)
    (read && !ack_ff && address == PCH_OFF_SIGNATURE) |=> (readdata == SIGNATURE))
    else $error("signature read wrong");
  ident_load_a: assert property (@(posedge clk) disable iff (!reset_n)
    (ld_state_ff == PCH_LD_WAIT && eeprom_valid) |=> (ident_ff == $past(eeprom_ident)))
    else $error("identity not loaded");
  wait_one_a: assert property (@(posedge clk) disable iff (!reset_n)
    (req && !ack_ff) |=> !waitrequest)
    else $error("answer not after one wait");

  sequence cmdstat_read_s;
    read && !ack_ff && address == PCH_OFF_CMDSTAT;
  endsequence

  sequence prst_rise_s;
    prst_s2_ff && !prst_d_ff;
  endsequence

  fetch_rearm_a: assert property (@(posedge clk) disable iff (!reset_n)
    prst_rise_s |=> eeprom_fetch)
    else $error("fetch not armed by reset release");
  scratch_write_a: assert property (@(posedge clk) disable iff (!reset_n)
    (wr_take && address == PCH_OFF_SCRATCH && byteenable[1])
      |=> (scratch_ff == $past(writedata[PCH_B_SCR_LO +: 8])))
    else $error("scratch byte not written");
  ident_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    !(ld_state_ff == PCH_LD_WAIT && eeprom_valid) |=> $stable(ident_ff))
    else $error("identity changed outside a load");
  flag_sticky_a: assert property (@(posedge clk) disable iff (!reset_n)
    (flag_clr == 5'h00) |=> ((flag_ff & $past(flag_ff)) == $past(flag_ff)))
    else $error("status flag dropped without clear");
  fixed_fields_a: assert property (@(posedge clk) disable iff (!reset_n)
    cmdstat_read_s |=> (readdata[PCH_B_SEL_LO +: 2] == PCH_SEL_TIMING && readdata[PCH_B_FBB]))
    else $error("fixed status field wrong");
  cap_mirror_a: assert property (@(posedge clk) disable iff (!reset_n)
    cmdstat_read_s |=> (readdata[PCH_B_NCAP] == $past(cap_list_bit)))
    else $error("capability bit not mirrored");
  reserved_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
    cmdstat_read_s |=> ((readdata & PCH_CS_RSVD_MASK) == 32'h0))
    else $error("reserved status bit not zero");
  irq_level_a: assert property (@(posedge clk) disable iff (!reset_n)
    irq == |(ev_stat_ff & ev_en_ff))
    else $error("interrupt level wrong");

endmodule // pch_config_regs

// >>> pch_loader_model.sv
// Serial EEPROM loader model answering identity fetches
`timescale 1ns/1ps
module pch_loader_model
  import pch_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Fetch handshake
  input wire logic eeprom_fetch,
  input wire logic [3:0] delay,
  input wire pch_pkg::pch_ident_t ident_val,
  output pch_pkg::pch_ident_t eeprom_ident,
  output logic eeprom_valid
);
  logic [3:0] cnt_ff;
  pch_ident_t last_ff;

  // Idle data is the inverse of the last word, so a stale latch never matches
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff <= 4'h0;
      eeprom_valid <= 1'b0;
      last_ff <= '0;
      eeprom_ident <= '1;
    end else if (eeprom_fetch && !eeprom_valid && cnt_ff == delay) begin
      cnt_ff <= 4'h0;
      eeprom_valid <= 1'b1;
      eeprom_ident <= ident_val;
      last_ff <= ident_val;
    end else begin
      cnt_ff <= (eeprom_fetch && !eeprom_valid) ? cnt_ff + 4'h1 : 4'h0;
      eeprom_valid <= 1'b0;
      eeprom_ident <= ~last_ff;
    end
  end
endmodule // pch_loader_model

// >>> pch_pkg.sv
// Package: offsets, field positions, reset values and carriers of the config header block
package pch_pkg;

  // ------------------------------------------------------------
  // Register offsets (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] PCH_OFF_ID = 8'h00;
  localparam logic [7:0] PCH_OFF_CMDSTAT = 8'h04;
  localparam logic [7:0] PCH_OFF_SCRATCH = 8'h40;
  localparam logic [7:0] PCH_OFF_SIGNATURE = 8'h80;
  localparam logic [7:0] PCH_OFF_IRQ_STAT = 8'hd0;
  localparam logic [7:0] PCH_OFF_IRQ_CLR = 8'hd4;
  localparam logic [7:0] PCH_OFF_IRQ_EN = 8'hd8;

  // ------------------------------------------------------------
  // Command/status and scratch field positions
  // ------------------------------------------------------------
  localparam int PCH_B_PERR = 31;
  localparam int PCH_B_SERR = 30;
  localparam int PCH_B_MABT = 29;
  localparam int PCH_B_TABT = 28;
  localparam int PCH_B_DPR = 24;
  localparam int PCH_B_FBB = 23;
  localparam int PCH_B_NCAP = 20;
  localparam int PCH_B_SERR_EN = 8;
  localparam int PCH_B_PAR_EN = 6;
  localparam int PCH_B_MST_EN = 2;
  localparam int PCH_B_MEM_EN = 1;
  localparam int PCH_B_IO_DIS = 0;
  localparam int PCH_B_SCR_LO = 8;
  localparam logic [1:0] PCH_SEL_TIMING = 2'h1;
  localparam int PCH_B_SEL_LO = 25;
  // Reserved command/status bits: 27, 22..21, 19..9, 7, 5..3
  localparam logic [31:0] PCH_CS_RSVD_MASK = 32'h086f_feb8;

  // Reset values
  localparam logic PCH_RST_SERR_EN = 1'b1;
  localparam logic PCH_RST_PAR_EN = 1'b0;
  localparam logic PCH_RST_MST_EN = 1'b1;
  localparam logic PCH_RST_MEM_EN = 1'b1;
  localparam logic PCH_RST_IO_DIS = 1'b1;
  localparam logic [7:0] PCH_RST_SCRATCH = 8'h00;

  // Interrupt status layout: one bit per sticky event flag
  localparam int PCH_NUM_EV = 5;

  // Loader sequencing
  localparam int PCH_LOAD_CYCLES = 4;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic parity_error;
    logic addr_parity_error;
    logic perr_seen;
    logic master_abort;
    logic target_abort;
  } pch_events_t;

  typedef struct packed {
    logic [15:0] device_id;
    logic [15:0] vendor_id;
  } pch_ident_t;

  typedef struct packed {
    logic system_error_response_enable;
    logic parity_response_enable;
    logic bus_master_enable;
    logic memory_space_enable;
    logic io_space_disable;
  } pch_cmd_t;

  typedef enum logic [1:0] {
    PCH_LD_IDLE = 2'b00,
    PCH_LD_WAIT = 2'b01,
    PCH_LD_DONE = 2'b10
  } pch_load_t;

endpackage

// >>> tb.sv
// Self-checking testbench of the configuration header block
`timescale 1ns/1ps
module tb;
  import pch_pkg::*;
  localparam logic [31:0] SIGNATURE_VAL = 32'h1234_abcd; // Arbitrary value
  logic clk;
  logic reset_n;
  logic [7:0] address;
  logic read;
  logic write;
  logic [3:0] byteenable;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic waitrequest;
  logic pci_reset_n;
  pch_ident_t eeprom_ident;
  logic eeprom_valid;
  logic eeprom_fetch;
  pch_events_t events;
  logic device_is_master;
  logic cap_list_bit;
  pch_cmd_t cmd;
  logic serr_assert;
  logic host_status_sys_err;
  logic master_allowed;
  logic irq;
  logic [3:0] ld_delay;
  pch_ident_t ld_ident;
  int n_errors;
  int checks_done;
  logic [31:0] rnd_state;
  pch_cmd_t exp_cmd;
  logic [4:0] exp_fl;
  logic [4:0] exp_is;
  logic [4:0] exp_en;

  pch_config_regs #(.SIGNATURE(SIGNATURE_VAL)) DUT (.clk(clk), .reset_n(reset_n),
    .address(address), .read(read), .write(write), .byteenable(byteenable),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .pci_reset_n(pci_reset_n), .eeprom_ident(eeprom_ident), .eeprom_valid(eeprom_valid),
    .eeprom_fetch(eeprom_fetch), .events(events), .device_is_master(device_is_master),
    .cap_list_bit(cap_list_bit), .cmd(cmd), .serr_assert(serr_assert),
    .host_status_sys_err(host_status_sys_err), .master_allowed(master_allowed), .irq(irq));

  pch_loader_model u_loader (.clk(clk), .reset_n(reset_n), .eeprom_fetch(eeprom_fetch),
    .delay(ld_delay), .ident_val(ld_ident), .eeprom_ident(eeprom_ident),
    .eeprom_valid(eeprom_valid));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] rand32();
    rnd_state = {rnd_state[30:0], rnd_state[31] ^ rnd_state[21] ^ rnd_state[1] ^ rnd_state[0]};
    return rnd_state;
  endfunction

  function automatic logic [31:0] cs_exp(logic [4:0] f, pch_cmd_t c, logic cap);
    logic [31:0] v;
    v = 32'h0;
    v[31:28] = f[4:1];
    v[24] = f[0];
    v[26:25] = 2'h1;
    v[23] = 1'b1;
    v[20] = cap;
    v[8] = c.system_error_response_enable;
    v[6] = c.parity_response_enable;
    v[2] = c.bus_master_enable;
    v[1] = c.memory_space_enable;
    v[0] = c.io_space_disable;
    return v;
  endfunction

  task automatic report_and_stop();
    if (n_errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask

  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [3:0] be,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    address <= a;
    byteenable <= be;
    writedata <= d;
    write <= wr;
    read <= !wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (n >= 20) chk("waitrequest", 32'h0, {31'h0, waitrequest});
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask

  task automatic wait_load();
    int n;
    n = 0;
    while (eeprom_fetch !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    while (eeprom_fetch !== 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    chk("load_wait", 32'h0, {31'h0, n >= 50});
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    #(100 * 20000);
    n_errors++;
    report_and_stop();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [31:0] q;
    logic [31:0] d;
    logic [3:0] be;
    logic dm;
    pch_events_t e;
    logic [7:0] exp_sc;
    reset_n = 1'b0;
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    byteenable = 4'h0;
    writedata = 32'h0;
    pci_reset_n = 1'b0;
    events = '0;
    device_is_master = 1'b0;
    cap_list_bit = 1'b1;
    ld_delay = 4'h0;
    n_errors = 0;
    checks_done = 0;
    rnd_state = 32'hef71;
    ld_ident = rand32();
    exp_cmd = 5'b10111;
    exp_fl = 5'h0;
    exp_is = 5'h0;
    exp_en = 5'h0;
    exp_sc = 8'h00;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    pci_reset_n <= 1'b1;
    chk("cmd_reset", exp_cmd, cmd);
    wait_load();
    bus(0, PCH_OFF_ID, 4'hf, 32'h0, q);
    chk("ident", ld_ident, q);
    bus(1, PCH_OFF_ID, 4'hf, ~ld_ident, q);
    bus(0, PCH_OFF_ID, 4'hf, 32'h0, q);
    chk("ident_ro", ld_ident, q);
    // Slow loader on the second release, new identity
    @(posedge clk);
    pci_reset_n <= 1'b0;
    ld_ident <= rand32();
    ld_delay <= 4'h5;
    repeat (3) @(posedge clk);
    pci_reset_n <= 1'b1;
    @(posedge clk);
    wait_load();
    bus(0, PCH_OFF_ID, 4'hf, 32'h0, q);
    chk("ident_reload", ld_ident, q);
    bus(0, PCH_OFF_CMDSTAT, 4'hf, 32'h0, q);
    chk("cmdstat_reset", cs_exp(5'h0, exp_cmd, 1'b1), q);
    bus(0, PCH_OFF_SCRATCH, 4'hf, 32'h0, q);
    chk("scratch_reset", 32'h0, q);
    for (int i = 0; i < 6; i++) begin
      d = rand32();
      be = i[0] ? 4'h2 : d[3:0];
      bus(1, PCH_OFF_SCRATCH, be, d, q);
      if (be[1]) exp_sc = d[15:8]; // Lane 1 carries the scratch byte
      bus(0, PCH_OFF_SCRATCH, 4'hf, 32'h0, q);
      chk("scratch", {16'h0, exp_sc, 8'h0}, q);
    end
    bus(1, PCH_OFF_SIGNATURE, 4'hf, rand32(), q);
    bus(0, PCH_OFF_SIGNATURE, 4'hf, 32'h0, q);
    chk("signature", SIGNATURE_VAL, q);
    bus(1, 8'h44, 4'hf, rand32(), q);
    bus(0, 8'h44, 4'hf, 32'h0, q);
    chk("unmapped", 32'h0, q);
    // Random command, event and interrupt traffic
    for (int i = 0; i < 24; i++) begin
      d = rand32();
      be = d[19:16];
      bus(1, PCH_OFF_CMDSTAT, be, d, q);
      if (be[0]) exp_cmd[3:0] = {d[6], d[2], d[1], d[0]};
      if (be[1]) exp_cmd.system_error_response_enable = d[8];
      if (be[3]) exp_fl = exp_fl & ~{d[31:28], d[24]};
      d = rand32();
      bus(1, PCH_OFF_IRQ_EN, 4'hf, d, q);
      exp_en = d[4:0];
      chk("cmd", exp_cmd, cmd);
      chk("master_allowed", exp_cmd.bus_master_enable, master_allowed);
      d = rand32();
      dm = d[4];
      e = '0;
      e.parity_error = d[0];
      e.perr_seen = d[0];
      e.addr_parity_error = d[0] & d[1];
      e.master_abort = d[2];
      e.target_abort = d[3];
      @(posedge clk);
      device_is_master <= dm;
      cap_list_bit <= d[5];
      events <= e;
      #1;
      chk("serr_assert", e.addr_parity_error & exp_cmd[4], serr_assert);
      chk("host_status_sys_err", e.parity_error & exp_cmd[3], host_status_sys_err);
      @(posedge clk);
      events <= '0;
      d = {e.parity_error, e.addr_parity_error & exp_cmd[4], e.master_abort & dm,
           e.target_abort & dm, e.perr_seen & dm & exp_cmd[3]};
      exp_fl = exp_fl | d[4:0];
      exp_is = exp_is | d[4:0];
      bus(0, PCH_OFF_CMDSTAT, 4'hf, 32'h0, q);
      chk("cmdstat", cs_exp(exp_fl, exp_cmd, cap_list_bit), q);
      bus(0, PCH_OFF_IRQ_STAT, 4'hf, 32'h0, q);
      chk("irq_status", {27'h0, exp_is}, q);
      chk("irq", |(exp_is & exp_en), irq);
      bus(0, PCH_OFF_IRQ_EN, 4'hf, 32'h0, q);
      chk("irq_enable", {27'h0, exp_en}, q);
      d = rand32();
      bus(1, PCH_OFF_IRQ_CLR, 4'hf, d, q);
      exp_is = exp_is & ~d[4:0];
    end
    // Reset again in mid-run
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    chk("cmd_rereset", 5'b10111, cmd);
    chk("irq_rereset", 32'h0, irq);
    bus(0, PCH_OFF_CMDSTAT, 4'hf, 32'h0, q);
    chk("cmdstat_rereset", cs_exp(5'h0, 5'b10111, cap_list_bit), q);
    report_and_stop();
  end
endmodule // tb
